// [rtl/ucrd_defs.svh]
`ifndef UCRD_DEFS_SVH
`define UCRD_DEFS_SVH
// ---------------------------------------------------------------
// slot addresses
// ---------------------------------------------------------------
`define UCRD_SLOT_0 3'h0
`define UCRD_SLOT_1 3'h1
`define UCRD_SLOT_2 3'h2
`define UCRD_SLOT_3 3'h3
`define UCRD_SLOT_4 3'h4
`define UCRD_SLOT_5 3'h5
`define UCRD_SLOT_6 3'h6
`define UCRD_SLOT_7 3'h7
// ---------------------------------------------------------------
// field positions and special values
// ---------------------------------------------------------------
`define UCRD_LC_DIV_BIT 7
`define UCRD_FC_SWAP_BIT 6
`define UCRD_LC_ENH 8'hbf
`define UCRD_DIV_ZERO 8'h00
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define UCRD_RST_ZERO 8'h00
`define UCRD_RST_ISTAT 8'h01
`define UCRD_RST_LSTAT 8'h60
`define UCRD_RST_SCRATCH 8'hff
`define UCRD_RST_EMS 8'h80
`endif

// [rtl/ucrd_pkg.sv]
package ucrd_pkg;
	// per-channel register state
	typedef struct packed {
		logic [7:0] tx_holding;
		logic tx_strobe;
		logic [7:0] divisor_low;
		logic [7:0] divisor_high;
		logic [7:0] alt_function;
		logic [7:0] interrupt_enable;
		logic [7:0] fifo_control;
		logic [7:0] line_control;
		logic [7:0] scratch_pad;
		logic [7:0] enhanced_mode_select;
		logic [7:0] fifo_trigger_level;
		logic [7:0] feature_control;
		logic [7:0] enhanced_function;
		logic [7:0] resume_char_one;
		logic [7:0] resume_char_two;
		logic [7:0] pause_char_one;
		logic [7:0] pause_char_two;
	} ucrd_chan_t;
	// access view selected by line control
	typedef enum logic [1:0] {
		UCRD_VIEW_NORMAL,
		UCRD_VIEW_DIVISOR,
		UCRD_VIEW_ENHANCED
	} ucrd_view_t;
endpackage

// [rtl/ucrd_regs.sv]
`include "ucrd_defs.svh"
module ucrd_regs #(
	parameter int NCH = 2,
	parameter logic [7:0] REV_CODE = 8'h01, // arbitrary value
	parameter logic [7:0] IDENT_CODE = 8'h5c // arbitrary value
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic channel_select,
	input wire logic [2:0] addr,
	input wire logic wr_stb,
	input wire logic rd_stb,
	input wire logic [7:0] wdata,
	input wire logic [8*NCH-1:0] rx_data,
	input wire logic [8*NCH-1:0] int_status,
	input wire logic [8*NCH-1:0] line_status,
	input wire logic [4*NCH-1:0] modem_lines,
	input wire logic [4*NCH-1:0] modem_delta,
	input wire logic [8*NCH-1:0] fifo_level,
	output logic [7:0] rdata,
	output logic [NCH-1:0] rx_pop,
	output logic [NCH-1:0] tx_push,
	output logic [8*NCH-1:0] tx_data,
	output logic [8*NCH-1:0] line_control_out,
	output logic [8*NCH-1:0] fifo_control_out
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		ucrd_pkg::ucrd_chan_t [NCH-1:0] ch;
		logic [7:0] rdata;
		logic [NCH-1:0] rx_pop;
	} ucrd_state_t;
	ucrd_state_t st_q; // registered state
	ucrd_state_t st_d; // next state
	// host inputs are on the bus clock domain, so no synchroniser
	logic sel_any; // chip selected
	assign sel_any = !cs_n;
	// ---------------------------------------------------------------
	// view per channel
	// ---------------------------------------------------------------
	function automatic ucrd_pkg::ucrd_view_t view_of(input logic [7:0] lc);
		if (lc == `UCRD_LC_ENH)
			return ucrd_pkg::UCRD_VIEW_ENHANCED;
		else if (lc[`UCRD_LC_DIV_BIT])
			return ucrd_pkg::UCRD_VIEW_DIVISOR;
		else
			return ucrd_pkg::UCRD_VIEW_NORMAL;
	endfunction
	// ---------------------------------------------------------------
	// next state: decode, writes and read data
	// ---------------------------------------------------------------
	always_comb begin
		ucrd_pkg::ucrd_chan_t c;
		ucrd_pkg::ucrd_view_t v;
		logic [7:0] r;
		logic zero_div;
		logic here;
		c = '0;
		v = ucrd_pkg::UCRD_VIEW_NORMAL;
		r = `UCRD_RST_ZERO;
		zero_div = 1'b0;
		here = 1'b0;
		st_d = st_q;
		st_d.rdata = st_q.rdata; // read data holds until next read
		st_d.rx_pop = '0;
		for (int i = 0; i < NCH; i++) begin
			c = st_q.ch[i];
			c.tx_strobe = 1'b0;
			v = view_of(c.line_control);
			here = sel_any && (channel_select == 1'(i));
			zero_div = (c.divisor_low == `UCRD_DIV_ZERO) &&
				(c.divisor_high == `UCRD_DIV_ZERO);
			// read mux
			r = `UCRD_RST_ZERO;
			case (addr)
				`UCRD_SLOT_0: begin
					if (v == ucrd_pkg::UCRD_VIEW_ENHANCED)
						r = fifo_level[8*i+:8];
					else if (v == ucrd_pkg::UCRD_VIEW_DIVISOR)
						r = zero_div ? REV_CODE : c.divisor_low;
					else
						r = rx_data[8*i+:8];
				end
				`UCRD_SLOT_1: begin
					if (v == ucrd_pkg::UCRD_VIEW_ENHANCED)
						r = c.feature_control;
					else if (v == ucrd_pkg::UCRD_VIEW_DIVISOR)
						r = zero_div ? IDENT_CODE : c.divisor_high;
					else
						r = c.interrupt_enable;
				end
				`UCRD_SLOT_2: begin
					if (v == ucrd_pkg::UCRD_VIEW_ENHANCED)
						r = c.enhanced_function;
					else if (v == ucrd_pkg::UCRD_VIEW_DIVISOR)
						r = c.alt_function;
					else
						r = int_status[8*i+:8];
				end
				`UCRD_SLOT_3: r = c.line_control;
				`UCRD_SLOT_4: begin
					// modem control lives elsewhere; reads zero here
					if (v == ucrd_pkg::UCRD_VIEW_ENHANCED)
						r = c.resume_char_one;
				end
				`UCRD_SLOT_5: begin
					if (v == ucrd_pkg::UCRD_VIEW_ENHANCED)
						r = c.resume_char_two;
					else
						r = line_status[8*i+:8];
				end
				`UCRD_SLOT_6: begin
					if (v == ucrd_pkg::UCRD_VIEW_ENHANCED)
						r = c.pause_char_one;
					else
						r = {modem_lines[4*i+:4],
							modem_delta[4*i+:4]};
				end
				`UCRD_SLOT_7: begin
					if (v == ucrd_pkg::UCRD_VIEW_ENHANCED)
						r = c.pause_char_two;
					else if (c.feature_control[`UCRD_FC_SWAP_BIT])
						r = fifo_level[8*i+:8];
					else
						r = c.scratch_pad;
				end
				default: r = `UCRD_RST_ZERO;
			endcase
			if (here && rd_stb) begin
				st_d.rdata = r;
				// only the rx slot pops; other reads are side-effect free
				st_d.rx_pop[i] = (addr == `UCRD_SLOT_0) &&
					(v == ucrd_pkg::UCRD_VIEW_NORMAL);
			end
			// writes
			if (here && wr_stb) begin
				case (addr)
					`UCRD_SLOT_0: begin
						if (v == ucrd_pkg::UCRD_VIEW_ENHANCED)
							c.fifo_trigger_level = wdata;
						else if (v == ucrd_pkg::UCRD_VIEW_DIVISOR)
							c.divisor_low = wdata;
						else begin
							c.tx_holding = wdata;
							c.tx_strobe = 1'b1;
						end
					end
					`UCRD_SLOT_1: begin
						if (v == ucrd_pkg::UCRD_VIEW_ENHANCED)
							c.feature_control = wdata;
						else if (v == ucrd_pkg::UCRD_VIEW_DIVISOR)
							c.divisor_high = wdata;
						else
							c.interrupt_enable = wdata;
					end
					`UCRD_SLOT_2: begin
						if (v == ucrd_pkg::UCRD_VIEW_ENHANCED)
							c.enhanced_function = wdata;
						else if (v == ucrd_pkg::UCRD_VIEW_DIVISOR)
							c.alt_function = wdata;
						else
							c.fifo_control = wdata;
					end
					`UCRD_SLOT_3: c.line_control = wdata;
					`UCRD_SLOT_4: begin
						if (v == ucrd_pkg::UCRD_VIEW_ENHANCED)
							c.resume_char_one = wdata;
					end
					`UCRD_SLOT_5: begin
						// status slot is reserved for writes
						if (v == ucrd_pkg::UCRD_VIEW_ENHANCED)
							c.resume_char_two = wdata;
					end
					`UCRD_SLOT_6: begin
						if (v == ucrd_pkg::UCRD_VIEW_ENHANCED)
							c.pause_char_one = wdata;
					end
					`UCRD_SLOT_7: begin
						if (v == ucrd_pkg::UCRD_VIEW_ENHANCED)
							c.pause_char_two = wdata;
						else if (c.feature_control[`UCRD_FC_SWAP_BIT])
							c.enhanced_mode_select = wdata;
						else
							c.scratch_pad = wdata;
					end
					default: c = c;
				endcase
			end
			st_d.ch[i] = c;
		end
	end
	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			st_q.rdata <= `UCRD_RST_ZERO;
			st_q.rx_pop <= '0;
			for (int i = 0; i < NCH; i++) begin
				// divisor resets undefined; zero chosen for determinism
				st_q.ch[i] <= '0;
				st_q.ch[i].scratch_pad <= `UCRD_RST_SCRATCH;
				st_q.ch[i].enhanced_mode_select <= `UCRD_RST_EMS;
			end
		end else begin
			st_q <= st_d;
		end
	end
	// ---------------------------------------------------------------
	// outputs straight from flops
	// ---------------------------------------------------------------
	assign rdata = st_q.rdata;
	assign rx_pop = st_q.rx_pop;
	for (genvar g = 0; g < NCH; g++) begin : g_out
		assign tx_push[g] = st_q.ch[g].tx_strobe;
		assign tx_data[8*g+:8] = st_q.ch[g].tx_holding;
		assign line_control_out[8*g+:8] = st_q.ch[g].line_control;
		assign fifo_control_out[8*g+:8] = st_q.ch[g].fifo_control;
	end
	// ---------------------------------------------------------------
	// assertions, channel 0 (the enhanced-view cover watches channel 1)
	// ---------------------------------------------------------------
	logic sel0;
	assign sel0 = !cs_n && !channel_select;
	// channel state with the tx strobe masked; that strobe drops by
	// itself one cycle after a push, so it is not expected to hold
	ucrd_pkg::ucrd_chan_t [NCH-1:0] ch_held;
	always_comb begin
		for (int k = 0; k < NCH; k++) begin
			ch_held[k] = st_q.ch[k];
			ch_held[k].tx_strobe = 1'b0;
		end
	end
	a_lc_write: assert property (@(posedge clk) disable iff (rst)
		sel0 && wr_stb && addr == `UCRD_SLOT_3
		|=> st_q.ch[0].line_control == $past(wdata))
		else $error("line control write lost");
	a_tx_push: assert property (@(posedge clk) disable iff (rst)
		sel0 && wr_stb && addr == `UCRD_SLOT_0 &&
		!st_q.ch[0].line_control[7] |=> tx_push[0] &&
		tx_data[7:0] == $past(wdata))
		else $error("tx holding not loaded");
	a_div_write: assert property (@(posedge clk) disable iff (rst)
		sel0 && wr_stb && addr == `UCRD_SLOT_0 &&
		st_q.ch[0].line_control[7] &&
		st_q.ch[0].line_control != `UCRD_LC_ENH
		|=> st_q.ch[0].divisor_low == $past(wdata) && !tx_push[0])
		else $error("divisor low write wrong");
	a_ident_read: assert property (@(posedge clk) disable iff (rst)
		sel0 && rd_stb && addr == `UCRD_SLOT_1 &&
		st_q.ch[0].line_control[7] &&
		st_q.ch[0].line_control != `UCRD_LC_ENH &&
		st_q.ch[0].divisor_low == 8'h00 &&
		st_q.ch[0].divisor_high == 8'h00 |=> rdata == IDENT_CODE)
		else $error("ident code not returned");
	a_ier_read: assert property (@(posedge clk) disable iff (rst)
		sel0 && rd_stb && addr == `UCRD_SLOT_1 &&
		!st_q.ch[0].line_control[7]
		|=> rdata == $past(st_q.ch[0].interrupt_enable))
		else $error("interrupt enable read wrong");
	a_status_read: assert property (@(posedge clk) disable iff (rst)
		sel0 && rd_stb && addr == `UCRD_SLOT_5 &&
		st_q.ch[0].line_control != `UCRD_LC_ENH
		|=> rdata == $past(line_status[7:0]))
		else $error("line status read wrong");
	a_lsr_nowrite: assert property (@(posedge clk) disable iff (rst)
		sel0 && wr_stb && addr == `UCRD_SLOT_5 &&
		st_q.ch[0].line_control != `UCRD_LC_ENH |=> $stable(ch_held))
		else $error("reserved write changed state");
	a_scratch_rt: assert property (@(posedge clk) disable iff (rst)
		sel0 && wr_stb && addr == `UCRD_SLOT_7 &&
		st_q.ch[0].line_control != `UCRD_LC_ENH &&
		!st_q.ch[0].feature_control[6]
		|=> st_q.ch[0].scratch_pad == $past(wdata))
		else $error("scratch pad write lost");
	a_enhanced_mode_select_write: assert property (@(posedge clk) disable iff (rst)
		sel0 && wr_stb && addr == `UCRD_SLOT_7 &&
		st_q.ch[0].line_control != `UCRD_LC_ENH &&
		st_q.ch[0].feature_control[6]
		|=> st_q.ch[0].enhanced_mode_select == $past(wdata) &&
		$stable(st_q.ch[0].scratch_pad))
		else $error("mode select write wrong");
	a_xoff_write: assert property (@(posedge clk) disable iff (rst)
		sel0 && wr_stb && addr == `UCRD_SLOT_7 &&
		st_q.ch[0].line_control == `UCRD_LC_ENH
		|=> st_q.ch[0].pause_char_two == $past(wdata))
		else $error("pause char write lost");
	c_tx_write: cover property (@(posedge clk) tx_push[0]);
	c_rx_pop: cover property (@(posedge clk) rx_pop[0]);
	c_enh_view: cover property (@(posedge clk)
		st_q.ch[1].line_control == `UCRD_LC_ENH);
	// divisor view and swapped slot 7 are the less common access paths
	c_div_view: cover property (@(posedge clk)
		st_q.ch[0].line_control[7] &&
		st_q.ch[0].line_control != `UCRD_LC_ENH);
	c_swap_read: cover property (@(posedge clk)
		sel0 && rd_stb && addr == `UCRD_SLOT_7 &&
		st_q.ch[0].feature_control[`UCRD_FC_SWAP_BIT]);
	// ---------------------------------------------------------------
	// assertions, views and shared slots, channel 0
	// ---------------------------------------------------------------
	// a zero divisor hides both divisor bytes behind the fixed codes
	a_rev_read: assert property (@(posedge clk) disable iff (rst)
		sel0 && rd_stb && addr == `UCRD_SLOT_0 &&
		st_q.ch[0].line_control[7] &&
		st_q.ch[0].line_control != `UCRD_LC_ENH &&
		st_q.ch[0].divisor_low == 8'h00 &&
		st_q.ch[0].divisor_high == 8'h00 |=> rdata == REV_CODE)
		else $error("revision code not returned");
	a_isr_read: assert property (@(posedge clk) disable iff (rst)
		sel0 && rd_stb && addr == `UCRD_SLOT_2 &&
		!st_q.ch[0].line_control[7]
		|=> rdata == $past(int_status[7:0]))
		else $error("interrupt status read wrong");
	a_fcr_write: assert property (@(posedge clk) disable iff (rst)
		sel0 && wr_stb && addr == `UCRD_SLOT_2 &&
		!st_q.ch[0].line_control[7]
		|=> fifo_control_out[7:0] == $past(wdata))
		else $error("fifo control write lost");
	a_afr_write: assert property (@(posedge clk) disable iff (rst)
		sel0 && wr_stb && addr == `UCRD_SLOT_2 &&
		st_q.ch[0].line_control[7] &&
		st_q.ch[0].line_control != `UCRD_LC_ENH
		|=> st_q.ch[0].alt_function == $past(wdata) &&
		$stable(fifo_control_out[7:0]))
		else $error("alternate function write wrong");
	a_efr_write: assert property (@(posedge clk) disable iff (rst)
		sel0 && wr_stb && addr == `UCRD_SLOT_2 &&
		st_q.ch[0].line_control == `UCRD_LC_ENH
		|=> st_q.ch[0].enhanced_function == $past(wdata))
		else $error("enhanced function write lost");
	a_trig_write: assert property (@(posedge clk) disable iff (rst)
		sel0 && wr_stb && addr == `UCRD_SLOT_0 &&
		st_q.ch[0].line_control == `UCRD_LC_ENH
		|=> st_q.ch[0].fifo_trigger_level == $past(wdata) && !tx_push[0])
		else $error("trigger level write wrong");
	a_msr_read: assert property (@(posedge clk) disable iff (rst)
		sel0 && rd_stb && addr == `UCRD_SLOT_6 &&
		st_q.ch[0].line_control != `UCRD_LC_ENH
		|=> rdata == {$past(modem_lines[3:0]),
		$past(modem_delta[3:0])})
		else $error("modem status read wrong");
	// ---------------------------------------------------------------
	// assertions, side effects and channel isolation
	// ---------------------------------------------------------------
	// a pop takes a byte from the receiver, so it may only follow a
	// normal-view read of the rx slot on this channel
	a_pop_source: assert property (@(posedge clk) disable iff (rst)
		rx_pop[0] |-> $past(sel0) && $past(rd_stb) &&
		$past(addr) == `UCRD_SLOT_0 &&
		!$past(st_q.ch[0].line_control[7]))
		else $error("rx pop without rx read");
	// a write to channel 0 must leave channel 1 untouched
	a_ch_isolate: assert property (@(posedge clk) disable iff (rst)
		sel0 && wr_stb |=> $stable(ch_held[1]))
		else $error("write leaked into other channel");
endmodule

// [bench/ucrd_core_model.sv]
// ---------------------------------------------------------------
// uart core side: status sources and pulse counters
// ---------------------------------------------------------------
module ucrd_core_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic [1:0] rx_pop,
	input wire logic [1:0] tx_push,
	output logic [15:0] rx_data,
	output logic [15:0] int_status,
	output logic [15:0] line_status,
	output logic [7:0] modem_lines,
	output logic [7:0] modem_delta,
	output logic [15:0] fifo_level,
	output logic [7:0] pops,
	output logic [7:0] pushes
);
	timeunit 1ns;
	timeprecision 1ps;
	// each channel shows its own values, so a crossed channel is seen
	assign rx_data = 16'hb1a0;
	assign int_status = 16'hc101;
	assign line_status = 16'h6160;
	assign modem_lines = 8'h5a;
	assign modem_delta = 8'h30;
	assign fifo_level = 16'h2211;
	// count pulses; a pulse counts once for every cycle it stays high
	always_ff @(posedge clk) begin
		if (rst) begin
			pops <= 8'h00;
			pushes <= 8'h00;
		end else begin
			pops <= pops + 8'(rx_pop[0]) + 8'(rx_pop[1]);
			pushes <= pushes + 8'(tx_push[0]) + 8'(tx_push[1]);
		end
	end
endmodule

// [bench/uart_channel_register_decode_tb.sv]
module uart_channel_register_decode_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic clk, rst, cs_n, channel_select, wr_stb, rd_stb;
	logic [2:0] addr;
	logic [7:0] wdata, rdata, pops, pushes, modem_lines, modem_delta;
	logic [15:0] rx_data, int_status, line_status, fifo_level;
	logic [15:0] tx_data, line_control_out, fifo_control_out;
	logic [1:0] rx_pop, tx_push;
	int num_errors = 0;
	int checks_done = 0;
	int i;
	ucrd_regs i_ucrd_regs (
		.clk(clk),
		.rst(rst),
		.cs_n(cs_n),
		.channel_select(channel_select),
		.addr(addr),
		.wr_stb(wr_stb),
		.rd_stb(rd_stb),
		.wdata(wdata),
		.rx_data(rx_data),
		.int_status(int_status),
		.line_status(line_status),
		.modem_lines(modem_lines),
		.modem_delta(modem_delta),
		.fifo_level(fifo_level),
		.rdata(rdata),
		.rx_pop(rx_pop),
		.tx_push(tx_push),
		.tx_data(tx_data),
		.line_control_out(line_control_out),
		.fifo_control_out(fifo_control_out)
	);
	ucrd_core_model i_ucrd_core_model (
		.clk(clk),
		.rst(rst),
		.rx_pop(rx_pop),
		.tx_push(tx_push),
		.rx_data(rx_data),
		.int_status(int_status),
		.line_status(line_status),
		.modem_lines(modem_lines),
		.modem_delta(modem_delta),
		.fifo_level(fifo_level),
		.pops(pops),
		.pushes(pushes)
	);
	// ---------------------------------------------------------------
	// clock and host access tasks
	// ---------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// request stands one cycle and is taken at the following edge
	task automatic wr(input logic ch, input logic [2:0] a,
		input logic [7:0] d);
		@(posedge clk);
		cs_n <= 1'b0;
		channel_select <= ch;
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		cs_n <= 1'b1;
		wr_stb <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic ch, input logic [2:0] a,
		input logic [7:0] e);
		@(posedge clk);
		cs_n <= 1'b0;
		channel_select <= ch;
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		cs_n <= 1'b1;
		rd_stb <= 1'b0;
		#1;
		chk(rdata, e);
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// watchdog: the sequence needs about 130 cycles
	initial begin
		repeat (3000) @(posedge clk);
		num_errors++;
		$display("[ERR] %0t watchdog expired", $time);
		end_sim;
	end
	// ---------------------------------------------------------------
	// test sequence
	// ---------------------------------------------------------------
	initial begin
		rst = 1'b1;
		cs_n = 1'b1;
		channel_select = 1'b0;
		addr = 3'h0;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		wdata = 8'h00;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		// reset view, line control clear
		rd(1'b0, 3'h1, 8'h00);
		rd(1'b0, 3'h2, 8'h01);
		rd(1'b1, 3'h2, 8'hc1);
		rd(1'b0, 3'h3, 8'h00);
		rd(1'b0, 3'h5, 8'h60);
		rd(1'b1, 3'h6, 8'h53);
		rd(1'b0, 3'h7, 8'hff);
		$display("test reset done");
		// normal view writes, channels kept apart
		wr(1'b1, 3'h7, 8'h5a);
		rd(1'b1, 3'h7, 8'h5a);
		rd(1'b0, 3'h7, 8'hff);
		// channel 1 alone in the enhanced view
		wr(1'b1, 3'h3, 8'hbf);
		chk(line_control_out[15:8], 8'hbf);
		wr(1'b1, 3'h4, 8'h66);
		rd(1'b1, 3'h4, 8'h66);
		rd(1'b0, 3'h4, 8'h00);
		wr(1'b1, 3'h3, 8'h00);
		rd(1'b1, 3'h4, 8'h00);
		wr(1'b0, 3'h1, 8'h8f);
		rd(1'b0, 3'h1, 8'h8f);
		wr(1'b0, 3'h5, 8'h12);
		wr(1'b0, 3'h6, 8'h34);
		rd(1'b0, 3'h5, 8'h60);
		rd(1'b0, 3'h6, 8'ha0);
		wr(1'b0, 3'h2, 8'hc9);
		chk(fifo_control_out[7:0], 8'hc9);
		rd(1'b0, 3'h2, 8'h01);
		wr(1'b0, 3'h0, 8'h3c);
		chk(tx_data[7:0], 8'h3c);
		rd(1'b0, 3'h0, 8'ha0);
		$display("test normal done");
		// divisor view, both bytes zero after reset
		wr(1'b0, 3'h3, 8'h80);
		chk(line_control_out[7:0], 8'h80);
		rd(1'b0, 3'h0, 8'h01);
		rd(1'b0, 3'h1, 8'h5c);
		wr(1'b0, 3'h0, 8'h12);
		rd(1'b0, 3'h0, 8'h12);
		rd(1'b0, 3'h1, 8'h00);
		chk(tx_data[7:0], 8'h3c);
		wr(1'b0, 3'h2, 8'h07);
		rd(1'b0, 3'h2, 8'h07);
		chk(fifo_control_out[7:0], 8'hc9);
		$display("test divisor done");
		// enhanced view
		wr(1'b0, 3'h3, 8'hbf);
		wr(1'b0, 3'h1, 8'h40);
		rd(1'b0, 3'h1, 8'h40);
		wr(1'b0, 3'h2, 8'h9e);
		rd(1'b0, 3'h2, 8'h9e);
		for (i = 4; i < 8; i++) begin
			wr(1'b0, i[2:0], 8'(8'h70 + i));
		end
		for (i = 4; i < 8; i++) begin
			rd(1'b0, i[2:0], 8'(8'h70 + i));
		end
		wr(1'b0, 3'h0, 8'h55);
		rd(1'b0, 3'h0, 8'h11);
		$display("test enhanced done");
		// swap bit set: slot 7 shows the level count
		wr(1'b0, 3'h3, 8'h03);
		rd(1'b0, 3'h7, 8'h11);
		wr(1'b0, 3'h7, 8'h44);
		rd(1'b0, 3'h7, 8'h11);
		rd(1'b0, 3'h1, 8'h8f);
		wr(1'b0, 3'h3, 8'hbf);
		wr(1'b0, 3'h1, 8'h00);
		wr(1'b0, 3'h3, 8'h03);
		rd(1'b0, 3'h7, 8'hff);
		@(posedge clk);
		#1;
		chk(pops, 8'h01);
		chk(pushes, 8'h01);
		$display("test swap done");
		// reset in mid-run brings the written registers back
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(1'b0, 3'h3, 8'h00);
		rd(1'b0, 3'h1, 8'h00);
		rd(1'b1, 3'h7, 8'hff);
		chk(fifo_control_out[7:0], 8'h00);
		$display("test reset again done");
		end_sim;
	end
endmodule
